// ==== core/hdbp_params.svh ====
/*
  Constants of the half-duplex back-pressure trigger: register map, field
  positions, reset values and duration figures.
  Assumes it is included by bare name into the package and the module.
*/
`ifndef HDBP_PARAMS_SVH
`define HDBP_PARAMS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define HDBP_ADDR_W          12
`define HDBP_CFG_ADDR        12'h02C
`define HDBP_STATUS_ADDR     12'h100
`define HDBP_CFG_RESET       32'h0000_0000

// ----------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------
`define HDBP_HI_MSB          23
`define HDBP_HI_LSB          16
`define HDBP_LO_MSB          15
`define HDBP_LO_LSB          8
`define HDBP_DUR_MSB         7
`define HDBP_DUR_LSB         4
`define HDBP_MC_BIT          3
`define HDBP_BC_BIT          2
`define HDBP_OWN_BIT         1
`define HDBP_ANY_BIT         0

// ----------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------
`define HDBP_ST_JAM_BIT      0
`define HDBP_ST_REACH_BIT    1
`define HDBP_ST_LEFT_MSB     28
`define HDBP_ST_LEFT_LSB     16

// ----------------------------------------------------------------------
// Timing: durations are counted in ticks of a tenth of a microsecond
// ----------------------------------------------------------------------
`define HDBP_CLK_NS          50
`define HDBP_TICK_NS         100
`define HDBP_UNIT_SHIFT      6
`define HDBP_D0_TENTHS       13'h0032
`define HDBP_D1_TENTHS       13'h0064
`define HDBP_D2_TENTHS       13'h0096
`define HDBP_D3_TENTHS       13'h00FA
`define HDBP_D4_TENTHS       13'h01F4
`define HDBP_D5_TENTHS       13'h03E8
`define HDBP_STEP_TENTHS     13'h01F4
`define HDBP_DF_TENTHS       13'h1770
`define HDBP_SLOW_TENTHS     13'h0016
`define HDBP_CODE_D4         4'h4
`define HDBP_CODE_D5         4'h5

`endif

// ==== core/hdbp_pkg.sv ====
/*
  Types of the half-duplex back-pressure trigger.
  Assumes hdbp_params.svh is on the include path.
*/
package hdbp_pkg;
  `include "hdbp_params.svh"

  typedef enum logic [0:0] {
    HDBP_IDLE = 1'b0,
    HDBP_JAM  = 1'b1
  } hdbp_mode_t;

  typedef struct packed {
    logic [7:0] flow_high_threshold;
    logic [7:0] flow_low_threshold;
    logic [3:0] backpressure_duration_select;
    logic       multicast_trigger_enable;
    logic       broadcast_trigger_enable;
    logic       own_address_trigger_enable;
    logic       any_frame_trigger_enable;
  } hdbp_cfg_t;

  // One-cycle destination decode result of a received frame.
  typedef struct packed {
    logic valid;
    logic multicast;
    logic broadcast;
    logic own_address;
  } hdbp_dest_t;

  typedef struct packed {
    logic [`HDBP_ADDR_W-1:0] paddr;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [31:0]             pwdata;
  } hdbp_apb_req_t;

  typedef struct packed {
    hdbp_cfg_t   cfg;
    hdbp_mode_t  mode;
    logic [12:0] tenths;
    logic [7:0]  pre;
    logic        jam;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } hdbp_regs_t;
endpackage

// ==== core/hdbp_trigger.sv ====
/*
  Half-duplex back-pressure trigger of the receive flow controller, with its
  configuration and status registers on an APB slave.
  Assumes all inputs are synchronous to i_sys_clk, the destination decode is
  a one-cycle pulse per frame and the receive FIFO level is given in bytes.
*/
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "hdbp_params.svh"

// Operation
// - Jam timer loads the period chosen by the duration code, config bits 7:4.
// - Duration code is ignored in full duplex.
// - 100 Mbps: 5,10,15,25,50 us; 100..550 us in 50 us steps; Fh 600 us.
// - 10 Mbps: 7.2,12.2,17.2,27.2,52.2; 5h 102.2, 9h 302.2, Bh 402.2, Ch 452.2 us.
// - Multicast enable, bit 3, jams on multicast frames past the threshold.
// - Broadcast enable, bit 2, jams on broadcast frames past the threshold.
// - Own-address enable, bit 1, jams on frames for this device past threshold.
// - Frame-class trigger enables do nothing in full duplex.
// - Threshold counts 64-byte units; each qualifying frame jams for the duration.
// - Any-frame enable, bit 0, overrides the three frame-class enables.
module hdbp_trigger #(
  parameter int P_TICK_CYCLES = `HDBP_TICK_NS / `HDBP_CLK_NS
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst_n,
  input  wire hdbp_pkg::hdbp_apb_req_t i_apb,
  output logic [31:0]                  o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic                    i_full_duplex,
  input  wire logic                    i_speed_100,
  input  wire logic [13:0]             i_rx_fifo_bytes,
  input  wire logic                    i_frame_start,
  input  wire hdbp_pkg::hdbp_dest_t    i_dest,
  output logic                         o_jam
);
  import hdbp_pkg::*;

  // ----------------------------------------------------------------------
  // Duration table
  // ----------------------------------------------------------------------
  function automatic logic [12:0] dur_tenths(input logic [3:0] code, input logic fast);
    logic [12:0] base;
    base = `HDBP_DF_TENTHS;
    case (code)
      4'h0: base = `HDBP_D0_TENTHS;
      4'h1: base = `HDBP_D1_TENTHS;
      4'h2: base = `HDBP_D2_TENTHS;
      4'h3: base = `HDBP_D3_TENTHS;
      4'h4: base = `HDBP_D4_TENTHS;
      4'hF: base = `HDBP_DF_TENTHS;
      default: begin
        base = 13'(`HDBP_D5_TENTHS + 13'(code - `HDBP_CODE_D5) * `HDBP_STEP_TENTHS);
      end
    endcase
    // The slower link needs extra jam time to cover its longer slot.
    return fast ? base : 13'(base + `HDBP_SLOW_TENTHS);
  endfunction

  // ----------------------------------------------------------------------
  // Trigger decision
  // ----------------------------------------------------------------------
  hdbp_regs_t  r_r;
  hdbp_regs_t  r_nxt;
  logic        reached;
  logic        class_hit;
  logic        trigger;
  logic        wr_en;
  logic        rd_setup;
  logic [13:0] level_bytes;

  assign level_bytes = {r_r.cfg.flow_high_threshold, `HDBP_UNIT_SHIFT'(0)};
  assign reached = i_rx_fifo_bytes >= level_bytes;

  always_comb begin
    class_hit = i_dest.valid &
                ((r_r.cfg.multicast_trigger_enable & i_dest.multicast) |
                 (r_r.cfg.broadcast_trigger_enable & i_dest.broadcast) |
                 (r_r.cfg.own_address_trigger_enable & i_dest.own_address));
    if (r_r.cfg.any_frame_trigger_enable) begin
      trigger = i_frame_start;
    end else begin
      trigger = class_hit;
    end
    trigger = trigger & reached & ~i_full_duplex;
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign wr_en    = i_apb.psel & i_apb.penable & r_r.pready & i_apb.pwrite;
  assign rd_setup = i_apb.psel & ~i_apb.penable;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    // Answer in the first access cycle: pready is raised at the setup edge.
    r_nxt.pready  = rd_setup;
    r_nxt.pslverr = 1'b0;
    if (rd_setup) begin
      r_nxt.prdata = 32'h0000_0000;
      case (i_apb.paddr)
        `HDBP_CFG_ADDR: begin
          r_nxt.prdata[`HDBP_HI_MSB:`HDBP_HI_LSB]   = r_r.cfg.flow_high_threshold;
          r_nxt.prdata[`HDBP_LO_MSB:`HDBP_LO_LSB]   = r_r.cfg.flow_low_threshold;
          r_nxt.prdata[`HDBP_DUR_MSB:`HDBP_DUR_LSB] = r_r.cfg.backpressure_duration_select;
          r_nxt.prdata[`HDBP_MC_BIT]  = r_r.cfg.multicast_trigger_enable;
          r_nxt.prdata[`HDBP_BC_BIT]  = r_r.cfg.broadcast_trigger_enable;
          r_nxt.prdata[`HDBP_OWN_BIT] = r_r.cfg.own_address_trigger_enable;
          r_nxt.prdata[`HDBP_ANY_BIT] = r_r.cfg.any_frame_trigger_enable;
        end
        `HDBP_STATUS_ADDR: begin
          r_nxt.prdata[`HDBP_ST_JAM_BIT]   = r_r.jam;
          r_nxt.prdata[`HDBP_ST_REACH_BIT] = reached;
          r_nxt.prdata[`HDBP_ST_LEFT_MSB:`HDBP_ST_LEFT_LSB] = r_r.tenths;
        end
        default: begin
          r_nxt.pslverr = 1'b1;
        end
      endcase
    end
    if (wr_en && i_apb.paddr == `HDBP_CFG_ADDR) begin
      r_nxt.cfg.flow_high_threshold = i_apb.pwdata[`HDBP_HI_MSB:`HDBP_HI_LSB];
      r_nxt.cfg.flow_low_threshold  = i_apb.pwdata[`HDBP_LO_MSB:`HDBP_LO_LSB];
      r_nxt.cfg.backpressure_duration_select = i_apb.pwdata[`HDBP_DUR_MSB:`HDBP_DUR_LSB];
      r_nxt.cfg.multicast_trigger_enable   = i_apb.pwdata[`HDBP_MC_BIT];
      r_nxt.cfg.broadcast_trigger_enable   = i_apb.pwdata[`HDBP_BC_BIT];
      r_nxt.cfg.own_address_trigger_enable = i_apb.pwdata[`HDBP_OWN_BIT];
      r_nxt.cfg.any_frame_trigger_enable   = i_apb.pwdata[`HDBP_ANY_BIT];
    end

    // Jam timer. A new qualifying frame restarts the full period.
    case (r_r.mode)
      HDBP_IDLE: begin
        r_nxt.jam = 1'b0;
      end
      HDBP_JAM: begin
        if (r_r.pre == 8'(P_TICK_CYCLES - 1)) begin
          r_nxt.pre = 8'h00;
          if (r_r.tenths == 13'h0001) begin
            r_nxt.tenths = 13'h0000;
            r_nxt.mode   = HDBP_IDLE;
            r_nxt.jam    = 1'b0;
          end else begin
            r_nxt.tenths = r_r.tenths - 13'h0001;
          end
        end else begin
          r_nxt.pre = 8'(r_r.pre + 8'h01);
        end
      end
      default: begin
        r_nxt.mode = HDBP_IDLE;
        r_nxt.jam  = 1'b0;
      end
    endcase
    if (trigger) begin
      r_nxt.mode   = HDBP_JAM;
      r_nxt.jam    = 1'b1;
      r_nxt.pre    = 8'h00;
      r_nxt.tenths = dur_tenths(r_r.cfg.backpressure_duration_select, i_speed_100);
    end
    // Full duplex stops any jam at once; the duration code is then unused.
    if (i_full_duplex) begin
      r_nxt.mode   = HDBP_IDLE;
      r_nxt.jam    = 1'b0;
      r_nxt.tenths = 13'h0000;
      r_nxt.pre    = 8'h00;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      r_r <= '0;
      r_r.cfg <= hdbp_cfg_t'(`HDBP_CFG_RESET);
      r_r.mode <= HDBP_IDLE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign o_prdata  = r_r.prdata;
  assign o_pready  = r_r.pready;
  assign o_pslverr = r_r.pslverr;
  assign o_jam     = r_r.jam;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_fdx_no_jam: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_full_duplex |=> !o_jam && r_r.tenths == 13'h0000)
    else $error("jam seen after full duplex cycle");

  a_fdx_no_trig: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_full_duplex && i_dest.valid && !o_jam |=> !o_jam)
    else $error("frame trigger acted in full duplex");

  a_mcast_trig: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_full_duplex && reached && !r_r.cfg.any_frame_trigger_enable
    && r_r.cfg.multicast_trigger_enable && i_dest.valid && i_dest.multicast
    |=> o_jam)
    else $error("multicast frame did not start jam");

  a_bcast_trig: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_full_duplex && reached && !r_r.cfg.any_frame_trigger_enable
    && r_r.cfg.broadcast_trigger_enable && i_dest.valid && i_dest.broadcast
    |=> o_jam)
    else $error("broadcast frame did not start jam");

  a_own_trig: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_full_duplex && reached && !r_r.cfg.any_frame_trigger_enable
    && r_r.cfg.own_address_trigger_enable && i_dest.valid && i_dest.own_address
    |=> o_jam)
    else $error("own-address frame did not start jam");

  a_any_over: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_jam && r_r.cfg.any_frame_trigger_enable && !i_frame_start && i_dest.valid
    |=> !o_jam)
    else $error("class trigger acted while any-frame mode set");

  a_below_lvl: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_jam && !reached |=> !o_jam)
    else $error("jam started below threshold");

  a_fast_dur: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trigger && i_speed_100 && r_r.cfg.backpressure_duration_select == `HDBP_CODE_D4
    |=> r_r.tenths == `HDBP_D4_TENTHS)
    else $error("wrong 100 Mbps duration loaded");

  a_slow_dur: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trigger && !i_speed_100 && r_r.cfg.backpressure_duration_select == 4'h0
    |=> r_r.tenths == 13'(`HDBP_D0_TENTHS + `HDBP_SLOW_TENTHS))
    else $error("wrong 10 Mbps duration loaded");

  a_step_dur: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trigger && i_speed_100 && r_r.cfg.backpressure_duration_select == 4'hE
    |=> r_r.tenths == 13'h157C)
    else $error("code E duration is not 550 us");

  a_jam_holds: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_jam && r_r.tenths > 13'h0001 && !i_full_duplex |=> o_jam)
    else $error("jam ended before its period");

  a_jam_load: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trigger |=> o_jam && r_r.pre == 8'h00)
    else $error("trigger did not start a fresh jam period");

  a_cfg_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    wr_en && i_apb.paddr == `HDBP_CFG_ADDR
    |=> r_r.cfg.backpressure_duration_select == $past(i_apb.pwdata[`HDBP_DUR_MSB:`HDBP_DUR_LSB]))
    else $error("duration code not stored by config write");

  a_jam_ends: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_jam && !trigger && r_r.tenths == 13'h0001 && r_r.pre == 8'(P_TICK_CYCLES - 1)
    |=> !o_jam)
    else $error("jam outlived its period");

  a_idle_quiet: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !o_jam && !trigger |=> !o_jam)
    else $error("jam started without a qualifying frame");

  a_any_frame: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_full_duplex && reached && r_r.cfg.any_frame_trigger_enable && i_frame_start
    |=> o_jam)
    else $error("any-frame mode did not start jam");

  a_fast_last: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trigger && i_speed_100 && r_r.cfg.backpressure_duration_select == 4'hF
    |=> r_r.tenths == `HDBP_DF_TENTHS)
    else $error("code F duration is not 600 us");

  a_slow_nine: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trigger && !i_speed_100 && r_r.cfg.backpressure_duration_select == 4'h9
    |=> r_r.tenths == 13'h0BCE)
    else $error("code 9 duration at 10 Mbps is not 302.2 us");

  a_slow_other: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    trigger && !i_speed_100 && r_r.cfg.backpressure_duration_select == 4'h7
    |=> r_r.tenths == 13'h07E6)
    else $error("code 7 duration at 10 Mbps is not 202.2 us");

  // ----------------------------------------------------------------------
  // Bus checks
  // ----------------------------------------------------------------------
  // A master that stretches its setup phase would trip the pulse check; that is intended.
  a_ready_setup: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_apb.psel && !i_apb.penable |=> o_pready)
    else $error("no ready in the first access cycle");

  a_ready_pulse: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_pready |=> !o_pready)
    else $error("ready held for more than one cycle");

  a_err_ready: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_pslverr |-> o_pready)
    else $error("slave error without ready");

  a_err_unmapped: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_apb.psel && !i_apb.penable && i_apb.paddr != `HDBP_CFG_ADDR
    && i_apb.paddr != `HDBP_STATUS_ADDR |=> o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
endmodule

// ==== sim/hdbp_station.sv ====
/*
  Remote half-duplex station that sends frame arrivals into the trigger.
  Assumes one clock shared with the bench; the bench calls send by hierarchy.
*/
`timescale 1ns/100ps
module hdbp_station (
  input  wire logic            i_clk,
  input  wire logic            i_jam,
  output logic                 o_frame_start,
  output hdbp_pkg::hdbp_dest_t o_dest
);
  import hdbp_pkg::*;

  initial begin
    o_frame_start = 1'b0;
    o_dest        = '0;
  end

  // A station defers while the segment carries a jam, as carrier sense would make it.
  task automatic send(input logic [2:0] cls, input logic st);
    int k;
    k = 0;
    while (i_jam === 1'b1 && k < 8000) begin
      @(posedge i_clk);
      k++;
    end
    @(posedge i_clk);
    o_dest        <= '{valid: |cls, multicast: cls[2], broadcast: cls[1], own_address: cls[0]};
    o_frame_start <= st;
    @(posedge i_clk);
    o_dest        <= '0;
    o_frame_start <= 1'b0;
  endtask
endmodule

// ==== sim/tb_hdbp_trigger.sv ====
/*
  Self-checking bench of the back-pressure trigger: registers over APB, frame
  classes, durations at both speeds, threshold and full duplex.
  Assumes the tick parameter is 1, so a jam lasts one cycle per tenth of a us.
*/
`timescale 1ns/100ps
`include "hdbp_params.svh"
module tb_hdbp_trigger;
  import hdbp_pkg::*;
  typedef struct packed {
    logic [3:0] en;
    logic [2:0] cls;
    logic       st;
    logic       fd;
    logic       ex;
  } hdbp_row_t;
  logic          clk;
  logic          rst_n;
  hdbp_apb_req_t apb_q;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          fd;
  logic          s100;
  logic [13:0]   bytes;
  logic          fst;
  hdbp_dest_t    dest;
  logic          jam;
  logic [31:0]   rd;
  logic          er;
  int            len;
  int            num_errors;
  int            n_tests;
  // Columns: enables, class (mc,bc,own), frame start, full duplex, jam expected.
  hdbp_row_t rows [12] = '{
    '{4'h8, 3'h4, 1'b0, 1'b0, 1'b1}, '{4'h8, 3'h2, 1'b0, 1'b0, 1'b0},
    '{4'h4, 3'h2, 1'b0, 1'b0, 1'b1}, '{4'h4, 3'h1, 1'b0, 1'b0, 1'b0},
    '{4'h2, 3'h1, 1'b0, 1'b0, 1'b1}, '{4'h2, 3'h4, 1'b0, 1'b0, 1'b0},
    '{4'hE, 3'h4, 1'b0, 1'b1, 1'b0}, '{4'hE, 3'h1, 1'b0, 1'b1, 1'b0},
    '{4'h1, 3'h4, 1'b0, 1'b0, 1'b0}, '{4'h1, 3'h0, 1'b1, 1'b0, 1'b1},
    '{4'h9, 3'h4, 1'b0, 1'b0, 1'b0}, '{4'h0, 3'h7, 1'b1, 1'b0, 1'b0}};
  logic [3:0] slow [10] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h9, 4'hB, 4'hC, 4'h7};

  hdbp_trigger #(.P_TICK_CYCLES(1)) dut_u (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_apb(apb_q), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_full_duplex(fd), .i_speed_100(s100),
    .i_rx_fifo_bytes(bytes), .i_frame_start(fst), .i_dest(dest), .o_jam(jam));
  hdbp_station station_u (.i_clk(clk), .i_jam(jam), .o_frame_start(fst), .o_dest(dest));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  always #25 clk = ~clk;

  // Expected jam length in tenths of a microsecond.
  function automatic logic [31:0] dur(input logic [3:0] c, input logic f100);
    logic [31:0] t;
    case (c)
      4'h0: t = 32'h0000_0032;
      4'h1: t = 32'h0000_0064;
      4'h2: t = 32'h0000_0096;
      4'h3: t = 32'h0000_00FA;
      4'h4: t = 32'h0000_01F4;
      4'hF: t = 32'h0000_1770;
      default: t = 32'h0000_03E8 + 32'h0000_01F4 * (c - 4'h5);
    endcase
    return f100 ? t : t + 32'h0000_0016;
  endfunction

  function automatic logic [31:0] cfg(input logic [7:0] hi, input logic [3:0] d,
                                      input logic [3:0] en);
    return {8'h00, hi, 8'h00, d, en};
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // The request stands until pready is seen high at a rising edge; data are taken there.
  // Only the watchdog ends a wait that never completes.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    apb_q <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: wd};
    @(posedge clk);
    apb_q.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    apb_q <= '0;
  endtask

  task automatic frame(input logic [2:0] c, input logic st);
    int k;
    station_u.send(c, st);
    len = 0;
    k = 0;
    @(negedge clk);
    while (jam !== 1'b1 && k < 3) begin
      @(negedge clk);
      k++;
    end
    while (jam === 1'b1 && len < 8000) begin
      len++;
      @(negedge clk);
    end
  endtask

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    apb_q = '0;
    fd = 1'b0;
    s100 = 1'b1;
    bytes = '0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, `HDBP_CFG_ADDR, cfg(8'h00, 4'h0, rows[i].en));
      fd <= rows[i].fd;
      frame(rows[i].cls, rows[i].st);
      check(len, rows[i].ex ? dur(4'h0, 1'b1) : 32'h0, "frame class row");
    end
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, `HDBP_CFG_ADDR, cfg(8'h00, c[3:0], 4'h8));
      fd <= 1'b0;
      frame(3'h4, 1'b0);
      check(len, dur(c[3:0], 1'b1), "fast duration");
    end
    foreach (slow[i]) begin
      apb(1'b1, `HDBP_CFG_ADDR, cfg(8'h00, slow[i], 4'h8));
      s100 <= 1'b0;
      frame(3'h4, 1'b0);
      check(len, dur(slow[i], 1'b0), "slow duration");
    end
    apb(1'b1, `HDBP_CFG_ADDR, cfg(8'h02, 4'h0, 4'h8));
    s100 <= 1'b1;
    bytes <= 14'h007F;
    frame(3'h4, 1'b0);
    check(len, 32'h0, "below threshold");
    apb(1'b1, `HDBP_CFG_ADDR, cfg(8'h02, 4'h0, 4'h8));
    bytes <= 14'h0080;
    frame(3'h4, 1'b0);
    check(len, dur(4'h0, 1'b1), "at threshold");
    apb(1'b0, `HDBP_CFG_ADDR, 32'h0);
    check(rd, cfg(8'h02, 4'h0, 4'h8), "config readback");
    // Reset, reserved bits and a refused address come after the frame and duration tests, before the status and full duplex checks.
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, `HDBP_CFG_ADDR, 32'h0);
    check(rd, `HDBP_CFG_RESET, "config reset");
    apb(1'b1, `HDBP_CFG_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, `HDBP_CFG_ADDR, 32'h0);
    check(rd, 32'h00FF_FFFF, "reserved bits");
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0000_0000, "unmapped read data");
    check(er, 1'b1, "unmapped read error");
    apb(1'b1, `HDBP_CFG_ADDR, cfg(8'h00, 4'hF, 4'h8));
    station_u.send(3'h4, 1'b0);
    repeat (10) @(posedge clk);
    apb(1'b0, `HDBP_STATUS_ADDR, 32'h0);
    check(rd[1:0], 32'h3, "status in jam");
    check(er, 1'b0, "status read error");
    check(rd[28:16], dur(4'hF, 1'b1) - 32'h0000_000B, "status time left");
    fd <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(jam, 1'b0, "full duplex drop");
    fd <= 1'b0;
    final_report();
  end
endmodule
